// ==== rxpf_pkg.sv ====
// rxpf_pkg: constants and carrier types of the receive pattern/accept filter.
// assumes a 32-bit word register port with byte addressing, one word every four bytes.
package rxpf_pkg;

	// ==========================================================
	// register offsets (byte addresses)
	localparam logic [7:0] ADDR_PAT_SUM   = 8'h00;
	localparam logic [7:0] ADDR_PAT_OFS   = 8'h04;
	localparam logic [7:0] ADDR_FILT_CFG  = 8'h08;
	localparam logic [7:0] ADDR_CTRL      = 8'h0c;
	localparam logic [7:0] ADDR_STATUS    = 8'h10;

	// ==========================================================
	// filter configuration fields
	localparam int FC_HASH_EN     = 15;
	localparam int FC_WAKE_EN     = 14;
	localparam int FC_INVERT      = 12;
	localparam int FC_QSEL_LO     = 8;
	localparam int FC_BAD_CRC     = 7;
	localparam int FC_GOOD_CRC    = 6;
	localparam int FC_SHORT_COLL  = 5;
	localparam int FC_SHORT_REJ   = 4;
	localparam int FC_OWN_UC      = 3;
	localparam int FC_FOREIGN_UC  = 2;
	localparam int FC_GROUP       = 1;
	localparam int FC_ALL_STA     = 0;
	// writable bits of the filter word; bit 13 and 31:16 stay zero
	localparam logic [31:0] FC_WMASK = 32'h0000dfff;
	localparam logic [31:0] LOW16_MASK = 32'h0000ffff;

	// control word: receive_on position
	localparam int CTRL_RX_ON = 8;

	// reset values
	localparam logic [15:0] PAT_SUM_RST  = 16'h0000;
	localparam logic [15:0] PAT_OFS_RST  = 16'h0000;
	localparam logic [31:0] FILT_CFG_RST = 32'h00000000;

	// ==========================================================
	// frame and pattern figures
	localparam logic [15:0] MIN_FRAME_BYTES = 16'h0040;
	localparam int          PAT_WINDOW      = 64;

	// pattern qualifier select codes
	localparam logic [3:0] QS_OFF       = 4'h0;
	localparam logic [3:0] QS_SUM_ONLY  = 4'h1;
	localparam logic [3:0] QS_STATION_A = 4'h2;
	localparam logic [3:0] QS_STATION_B = 4'h3;
	localparam logic [3:0] QS_UCAST_A   = 4'h4;
	localparam logic [3:0] QS_UCAST_B   = 4'h5;
	localparam logic [3:0] QS_BCAST_A   = 4'h6;
	localparam logic [3:0] QS_BCAST_B   = 4'h7;
	localparam logic [3:0] QS_HASH      = 4'h8;
	localparam logic [3:0] QS_WAKE      = 4'h9;

	// qualifiers of a frame, valid with the frame end strobe
	typedef struct packed {
		logic crc_ok;
		logic da_station;
		logic da_unicast;
		logic da_multicast;
		logic da_broadcast;
		logic hash_hit;
		logic wake_frame;
	} rxpf_frame_info_type;

	// verdict of a frame
	typedef struct packed {
		logic        accepted;
		logic        pattern_hit;
		logic        sum_equal;
		logic        runt;
		logic [15:0] sum;
	} rxpf_verdict_type;

endpackage : rxpf_pkg

// ==== rxpf_filter.sv ====
// rxpf_filter: receive acceptance filter with pattern checksum matching.
// assumes a byte stream from the receive mac, qualifiers from the address,
// hash and wake-frame detectors, and mask bits from the mask registers.
// Behaviour
// - high halfword of three words reads zero
// - expected checksum register, two bytes, reset zero
// - offset register sets pattern start, reset zero
// - settings steer receive only, never transmit
// - qualifier select bits 11:8, zero means off
// - bit 15 enables hash-table acceptance
// - bit 14 enables wake-frame acceptance
// - bit 13 reads zero, writes ignored
// - bit 12 inverts the checksum criterion
// - inversion and equality combine by xor
// - hash qualifier checked regardless of enable
// - wake-frame qualifier checked regardless of enable
// - select codes pick extra pattern qualifications
// - runt reject and runt collect below 64
// - crc good required, or crc bad collected
// - own unicast and foreign unicast acceptance
`timescale 1ns/10ps

module rxpf_filter
	import rxpf_pkg::*;
(
	// clock and reset
	input  wire logic                clk,
	input  wire logic                reset_n,
	// register port
	input  wire logic [7:0]          reg_addr,
	input  wire logic [31:0]         reg_wdata,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	output logic [31:0]              reg_rdata,
	// receive byte stream
	input  wire logic                rx_frame_start,
	input  wire logic                rx_byte_valid,
	input  wire logic [7:0]          rx_byte,
	input  wire logic                rx_frame_end,
	input  rxpf_frame_info_type      rx_info,
	// pattern mask from the mask registers
	input  wire logic [63:0]         pattern_mask,
	// verdict
	output logic                     receive_on,
	output logic                     verdict_valid,
	output rxpf_verdict_type         verdict
);

	// ==========================================================
	// frame tracking state
	typedef enum logic {ST_IDLE, ST_FRAME} rxpf_state_type;
	rxpf_state_type state_r;

	// ==========================================================
	// configuration registers
	logic [15:0] expected_pattern_sum_r;
	logic [15:0] pattern_start_offset_r;
	logic [31:0] receive_filter_config_r;
	logic        receive_on_r;
	logic [31:0] rd_data_r;

	wire logic wr_sum  = reg_wr && (reg_addr == ADDR_PAT_SUM);
	wire logic wr_ofs  = reg_wr && (reg_addr == ADDR_PAT_OFS);
	wire logic wr_cfg  = reg_wr && (reg_addr == ADDR_FILT_CFG);
	wire logic wr_ctrl = reg_wr && (reg_addr == ADDR_CTRL);

	// writes are taken at any time; keeping them away from live traffic
	// is left to software
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			expected_pattern_sum_r <= PAT_SUM_RST;
		end else if (wr_sum) begin
			expected_pattern_sum_r <= reg_wdata[15:0];
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pattern_start_offset_r <= PAT_OFS_RST;
		end else if (wr_ofs) begin
			pattern_start_offset_r <= reg_wdata[15:0];
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			receive_filter_config_r <= FILT_CFG_RST;
		end else if (wr_cfg) begin
			// bit 13 and the high half are never stored
			receive_filter_config_r <= reg_wdata & FC_WMASK;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			receive_on_r <= 1'b0;
		end else if (wr_ctrl) begin
			receive_on_r <= reg_wdata[CTRL_RX_ON];
		end
	end

	// ==========================================================
	// configuration fields
	wire logic       hash_filter_enable =
		receive_filter_config_r[FC_HASH_EN];
	wire logic       wake_frame_filter_enable =
		receive_filter_config_r[FC_WAKE_EN];
	wire logic       pattern_invert = receive_filter_config_r[FC_INVERT];
	wire logic [3:0] pattern_qualifier_select =
		receive_filter_config_r[FC_QSEL_LO +: 4];
	wire logic       bad_crc_collect = receive_filter_config_r[FC_BAD_CRC];
	wire logic       good_crc_require =
		receive_filter_config_r[FC_GOOD_CRC];
	wire logic       short_frame_collect =
		receive_filter_config_r[FC_SHORT_COLL];
	wire logic       short_frame_reject =
		receive_filter_config_r[FC_SHORT_REJ];
	wire logic       own_unicast_accept = receive_filter_config_r[FC_OWN_UC];
	wire logic       foreign_unicast_accept =
		receive_filter_config_r[FC_FOREIGN_UC];
	wire logic       group_address_accept = receive_filter_config_r[FC_GROUP];
	wire logic       all_stations_accept = receive_filter_config_r[FC_ALL_STA];

	// ==========================================================
	// bytes count only inside a frame; no transmit side here
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= ST_IDLE;
		end else begin
			unique case (state_r)
				ST_IDLE: begin
					if (rx_frame_start && receive_on_r) begin
						state_r <= ST_FRAME;
					end
				end
				ST_FRAME: begin
					if (rx_frame_end) begin
						state_r <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// ==========================================================
	// byte position and length
	logic [15:0] byte_cnt_r;
	logic [15:0] byte_cnt_nxt;

	always_comb begin
		byte_cnt_nxt = byte_cnt_r;
		if (rx_frame_start) begin
			byte_cnt_nxt = 16'h0000;
		end else if (state_r == ST_FRAME && rx_byte_valid &&
				byte_cnt_r != 16'hffff) begin
			// saturate: lengths beyond the counter still count as long
			byte_cnt_nxt = byte_cnt_r + 16'h0001;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			byte_cnt_r <= 16'h0000;
		end else begin
			byte_cnt_r <= byte_cnt_nxt;
		end
	end

	// ==========================================================
	// pattern checksum over masked bytes from the offset onward
	wire logic [15:0] rel_pos = byte_cnt_r - pattern_start_offset_r;
	wire logic        in_window = (byte_cnt_r >= pattern_start_offset_r) &&
		(rel_pos < 16'(PAT_WINDOW));
	wire logic        byte_sel = in_window && pattern_mask[rel_pos[5:0]];

	// even positions are the high byte of a word, odd the low byte
	wire logic [15:0] sum_term = rel_pos[0] ? {8'h00, rx_byte} :
		{rx_byte, 8'h00};

	logic [15:0] sum_acc_r;
	logic [15:0] sum_acc_nxt;
	logic [16:0] sum_wide;

	always_comb begin
		sum_wide    = {1'b0, sum_acc_r} + {1'b0, sum_term};
		sum_acc_nxt = sum_acc_r;
		if (rx_frame_start) begin
			sum_acc_nxt = 16'h0000;
		end else if (state_r == ST_FRAME && rx_byte_valid && byte_sel) begin
			// ones-complement add with end-around carry
			sum_acc_nxt = sum_wide[15:0] + {15'h0000, sum_wide[16]};
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sum_acc_r <= 16'h0000;
		end else begin
			sum_acc_r <= sum_acc_nxt;
		end
	end

	// ==========================================================
	// decision terms, judged on the frame end strobe
	wire logic [15:0] sum_final = ~sum_acc_r;
	wire logic        sum_equal = (sum_final == expected_pattern_sum_r);
	// true when exactly one of inversion and equality holds
	wire logic        sum_cond = pattern_invert ^ sum_equal;

	logic pattern_hit;
	always_comb begin
		pattern_hit = 1'b0;
		unique case (pattern_qualifier_select)
			QS_OFF: begin
				pattern_hit = 1'b0;
			end
			QS_SUM_ONLY: begin
				pattern_hit = sum_cond;
			end
			QS_STATION_A, QS_STATION_B: begin
				pattern_hit = sum_cond && rx_info.da_station;
			end
			QS_UCAST_A, QS_UCAST_B: begin
				pattern_hit = sum_cond && rx_info.da_unicast;
			end
			QS_BCAST_A, QS_BCAST_B: begin
				pattern_hit = sum_cond && rx_info.da_broadcast;
			end
			QS_HASH: begin
				// hash hit counts whatever the hash enable says
				pattern_hit = sum_cond && rx_info.hash_hit;
			end
			QS_WAKE: begin
				pattern_hit = sum_cond && rx_info.wake_frame;
			end
			default: begin
				// codes above nine are undefined: never a match
				pattern_hit = 1'b0;
			end
		endcase
	end

	wire logic is_runt = (byte_cnt_r < MIN_FRAME_BYTES);

	// qualifying gates: every enabled one must pass
	wire logic crc_pass =
		(!good_crc_require || rx_info.crc_ok) &&
		(!bad_crc_collect  || !rx_info.crc_ok);
	wire logic runt_pass =
		(!short_frame_reject  || !is_runt) &&
		(!short_frame_collect || is_runt);

	// address and content filters: any enabled one accepts
	wire logic own_uc_hit = own_unicast_accept && rx_info.da_unicast &&
		rx_info.da_station;
	wire logic foreign_uc_hit = foreign_unicast_accept &&
		rx_info.da_unicast && !rx_info.da_station;
	wire logic group_hit = group_address_accept && rx_info.da_multicast;
	wire logic bcast_hit = all_stations_accept && rx_info.da_broadcast;
	wire logic hash_hit  = hash_filter_enable && rx_info.hash_hit;
	wire logic wake_hit  = wake_frame_filter_enable &&
		rx_info.wake_frame;

	wire logic any_hit = own_uc_hit || foreign_uc_hit || group_hit ||
		bcast_hit || hash_hit || wake_hit || pattern_hit;
	wire logic frame_done = (state_r == ST_FRAME) && rx_frame_end;

	// ==========================================================
	// verdict, one cycle after the frame end strobe
	logic             verdict_valid_r;
	rxpf_verdict_type verdict_r;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			verdict_valid_r <= 1'b0;
		end else begin
			verdict_valid_r <= frame_done;
		end
	end

	// the verdict is held until the next frame ends, so status reads it
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			verdict_r <= '0;
		end else if (frame_done) begin
			verdict_r.accepted    <= crc_pass && runt_pass && any_hit;
			verdict_r.pattern_hit <= pattern_hit;
			verdict_r.sum_equal   <= sum_equal;
			verdict_r.runt        <= is_runt;
			verdict_r.sum         <= sum_final;
		end
	end

	// ==========================================================
	// register read: data only in the cycle after the strobe
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h00000000;
		unique case (reg_addr)
			ADDR_PAT_SUM: begin
				rd_mux = {16'h0000, expected_pattern_sum_r};
			end
			ADDR_PAT_OFS: begin
				rd_mux = {16'h0000, pattern_start_offset_r};
			end
			ADDR_FILT_CFG: begin
				rd_mux = receive_filter_config_r & LOW16_MASK;
			end
			ADDR_CTRL: begin
				rd_mux[CTRL_RX_ON] = receive_on_r;
			end
			ADDR_STATUS: begin
				rd_mux = {verdict_r.sum, 12'h000, verdict_r.runt,
					verdict_r.sum_equal, verdict_r.pattern_hit,
					verdict_r.accepted};
			end
			default: begin
				rd_mux = 32'h00000000;
			end
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_data_r <= 32'h00000000;
		end else begin
			rd_data_r <= reg_rd ? rd_mux : 32'h00000000;
		end
	end

	// ==========================================================
	// outputs
	assign reg_rdata     = rd_data_r;
	assign receive_on    = receive_on_r;
	assign verdict_valid = verdict_valid_r;
	assign verdict       = verdict_r;

endmodule : rxpf_filter

// ==== rxpf_filter_sva.sv ====
// rxpf_filter_sva: port checker for the receive pattern/accept filter.
// assumes settings are written only while receive is off, as software must.
`timescale 1ns/10ps

module rxpf_filter_sva
	import rxpf_pkg::*;
(
	// clock and reset
	input wire logic          clk,
	input wire logic          reset_n,
	// register port
	input wire logic [7:0]    reg_addr,
	input wire logic [31:0]   reg_wdata,
	input wire logic          reg_wr,
	input wire logic          reg_rd,
	input wire logic [31:0]   reg_rdata,
	// frame side
	input wire logic          rx_frame_end,
	input rxpf_frame_info_type rx_info,
	input wire logic          verdict_valid,
	input rxpf_verdict_type   verdict
);
	// ========
	// shadow of the settings, rebuilt from the writes seen
	logic [15:0] cfg_r;
	logic [15:0] sum_r;
	logic [3:0]  qsel;
	logic        xr;
	logic        hit_hash;
	logic        hit_wake;
	logic        crc_good;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cfg_r <= 16'h0000;
		end else if (reg_wr && reg_addr == ADDR_FILT_CFG) begin
			cfg_r <= reg_wdata[15:0] & FC_WMASK[15:0];
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sum_r <= 16'h0000;
		end else if (reg_wr && reg_addr == ADDR_PAT_SUM) begin
			sum_r <= reg_wdata[15:0];
		end
	end

	assign qsel     = cfg_r[11:8];
	assign xr       = cfg_r[FC_INVERT] ^ verdict.sum_equal;
	assign hit_hash = rx_info.hash_hit;
	assign hit_wake = rx_info.wake_frame;
	assign crc_good = rx_info.crc_ok;

	// ========
	// properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	// the status word carries the sum high, so it is left out here
	sequence s_read;
		reg_rd && (reg_addr == ADDR_PAT_SUM || reg_addr == ADDR_PAT_OFS ||
			reg_addr == ADDR_FILT_CFG);
	endsequence
	sequence s_cfg_read;
		reg_rd && reg_addr == ADDR_FILT_CFG;
	endsequence
	sequence s_verdict(logic [3:0] code);
		verdict_valid && qsel == code;
	endsequence

	a_high_half_zero: assert property (s_read |=> reg_rdata[31:16] == 16'h0000)
		else $error("upper half of read word not zero");
	a_bit13_zero: assert property (s_cfg_read |=> !reg_rdata[13])
		else $error("bit 13 of filter word read as one");
	a_verdict_cause: assert property (verdict_valid |-> $past(rx_frame_end))
		else $error("verdict without a frame end before it");
	a_verdict_pulse: assert property (verdict_valid |=> !verdict_valid)
		else $error("verdict strobe longer than one cycle");
	a_sum_compare: assert property (verdict_valid |->
		verdict.sum_equal == (verdict.sum == sum_r))
		else $error("sum equal flag disagrees with stored sum");
	a_mode_off: assert property (s_verdict(QS_OFF) |-> !verdict.pattern_hit)
		else $error("pattern hit while matching is off");
	a_invert_xor: assert property (s_verdict(QS_SUM_ONLY) |-> verdict.pattern_hit == xr)
		else $error("pattern hit is not invert xor equal");
	a_hash_mode: assert property (s_verdict(QS_HASH) |->
		verdict.pattern_hit == (xr && $past(hit_hash)))
		else $error("hash qualified pattern hit wrong");
	a_wake_mode: assert property (s_verdict(QS_WAKE) |->
		verdict.pattern_hit == (xr && $past(hit_wake)))
		else $error("wake qualified pattern hit wrong");
	a_runt_reject: assert property (verdict_valid && cfg_r[FC_SHORT_REJ] &&
		verdict.runt |-> !verdict.accepted)
		else $error("short frame accepted while rejected");
	a_crc_gate: assert property (verdict_valid && cfg_r[FC_GOOD_CRC] |->
		!verdict.accepted || $past(crc_good))
		else $error("bad crc frame accepted");
endmodule : rxpf_filter_sva

bind rxpf_filter rxpf_filter_sva u_rxpf_filter_sva (.clk(clk),
	.reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.rx_frame_end(rx_frame_end), .rx_info(rx_info),
	.verdict_valid(verdict_valid), .verdict(verdict));

// ==== tb_top.sv ====
// tb_top: register and frame bench for the receive filter.
// assumes a 20 MHz clock and read data one cycle after the read strobe.
`timescale 1ns/10ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; \
	$display("ERROR t=%0t got %h exp %h", $time, g, e); end end

module tb_top
	import rxpf_pkg::*;
;
	logic                clk;
	logic                reset_n;
	logic [7:0]          reg_addr;
	logic [31:0]         reg_wdata;
	logic [31:0]         reg_rdata;
	logic                reg_wr;
	logic                reg_rd;
	logic                rx_frame_start;
	logic                rx_byte_valid;
	logic                rx_frame_end;
	logic [7:0]          rx_byte;
	rxpf_frame_info_type rx_info;
	logic [63:0]         pattern_mask;
	logic                receive_on;
	logic                verdict_valid;
	rxpf_verdict_type    verdict;
	int                  errors;
	int                  check_count;
	// filter cases: bit i of t_short picks a 40 byte frame, t_acc the verdict
	logic [15:0] t_cfg [13] = '{16'h0001, 16'h0001, 16'h0011, 16'h0021,
		16'h0021, 16'h0041, 16'h0081, 16'h0008, 16'h0004, 16'h0004,
		16'h8000, 16'h4000, 16'h0002};
	logic [6:0]  t_info [13] = '{7'h44, 7'h40, 7'h44, 7'h44, 7'h44, 7'h04,
		7'h04, 7'h70, 7'h70, 7'h50, 7'h42, 7'h41, 7'h48};
	logic [12:0] t_short = 13'h000c;
	logic [12:0] t_acc   = 13'h1ec9;

	rxpf_filter u_rxpf_filter (.clk(clk), .reset_n(reset_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.rx_frame_start(rx_frame_start), .rx_byte_valid(rx_byte_valid),
		.rx_byte(rx_byte), .rx_frame_end(rx_frame_end), .rx_info(rx_info),
		.pattern_mask(pattern_mask), .receive_on(receive_on),
		.verdict_valid(verdict_valid), .verdict(verdict));

	initial clk = 1'b0;
	always #25 clk = ~clk;

	// ========
	// access tasks
	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : reg_write

	task automatic reg_check(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		`CHK(reg_rdata, e)
	endtask : reg_check

	// one's complement over the masked window, bytes past the end are zero
	function automatic logic [15:0] exp_sum(input int n, input int ofs);
		logic [16:0] acc;
		logic [7:0]  b;
		acc = 17'h00000;
		for (int i = 0; i < PAT_WINDOW; i++) begin
			b = (ofs + i < n && pattern_mask[i]) ? 8'(3 * (ofs + i) + 1) : 8'h00;
			acc = acc + ((i % 2 == 0) ? {1'b0, b, 8'h00} : {9'h000, b});
			acc = {1'b0, acc[15:0]} + {16'h0000, acc[16]};
		end
		return ~acc[15:0];
	endfunction : exp_sum

	task automatic frame(input int n, input logic [6:0] info, input logic vv);
		@(posedge clk);
		rx_frame_start <= 1'b1;
		@(posedge clk);
		rx_frame_start <= 1'b0;
		for (int i = 0; i < n; i++) begin
			rx_byte_valid <= 1'b1;
			rx_byte <= 8'(3 * i + 1);
			@(posedge clk);
		end
		rx_byte_valid <= 1'b0;
		rx_byte <= 8'h5a;
		rx_frame_end <= 1'b1;
		rx_info <= rxpf_frame_info_type'(info);
		@(posedge clk);
		rx_frame_end <= 1'b0;
		@(negedge clk);
		`CHK(verdict_valid, vv)
	endtask : frame

	task automatic run_case(input logic [15:0] cfg, input logic [6:0] info,
		input int n, input logic acc, input logic hit);
		reg_write(ADDR_CTRL, 32'h00000000);
		reg_write(ADDR_FILT_CFG, {16'h0000, cfg});
		reg_write(ADDR_CTRL, 32'h00000100);
		frame(n, info, 1'b1);
		`CHK(receive_on, 1'b1)
		`CHK(verdict.accepted, acc)
		`CHK(verdict.pattern_hit, hit)
		`CHK(verdict.runt, 1'(n < 64))
		`CHK(verdict.sum, exp_sum(n, 2))
	endtask : run_case

	task automatic end_sim;
		if (errors == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_sim

	// ========
	// tests
	initial begin
		reset_n = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h00000000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		rx_frame_start = 1'b0;
		rx_byte_valid = 1'b0;
		rx_frame_end = 1'b0;
		rx_byte = 8'h00;
		rx_info = '0;
		pattern_mask = 64'hffffffffffffffdf;
		errors = 0;
		check_count = 0;
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		reg_check(ADDR_PAT_SUM, 32'h00000000);
		reg_check(ADDR_PAT_OFS, 32'h00000000);
		reg_check(ADDR_FILT_CFG, 32'h00000000);
		reg_check(ADDR_CTRL, 32'h00000000);
		reg_write(ADDR_PAT_SUM, 32'hffffffff);
		reg_check(ADDR_PAT_SUM, 32'h0000ffff);
		reg_write(ADDR_PAT_OFS, 32'hffffffff);
		reg_check(ADDR_PAT_OFS, 32'h0000ffff);
		reg_write(ADDR_FILT_CFG, 32'hffffffff);
		reg_check(ADDR_FILT_CFG, 32'h0000dfff);
		reg_write(8'h20, 32'hffffffff);
		reg_check(8'h20, 32'h00000000);
		// receive still off: no verdict expected
		frame(70, 7'h44, 1'b0);
		reg_write(ADDR_PAT_OFS, 32'h00000002);
		reg_write(ADDR_PAT_SUM, {16'h0000, exp_sum(70, 2)});
		for (int v = 0; v < 2; v++)
			for (int q = 0; q < 10; q++)
				for (int k = 0; k < 2; k++)
					run_case(16'((v << 12) | (q << 8)), k ? 7'h7f : 7'h40, 70,
						q != 0 && v == 0 && (q == 1 || k == 1),
						q != 0 && v == 0 && (q == 1 || k == 1));
		// wrong expected sum: only the inverted criterion hits
		reg_write(ADDR_CTRL, 32'h00000000);
		reg_write(ADDR_PAT_SUM, {16'h0000, ~exp_sum(70, 2)});
		run_case(16'h1100, 7'h40, 70, 1'b1, 1'b1);
		reg_check(ADDR_STATUS, {exp_sum(70, 2), 16'h0003});
		run_case(16'h0100, 7'h40, 70, 1'b0, 1'b0);
		// codes above nine never match, even with the criterion met
		run_case(16'h1a00, 7'h7f, 70, 1'b0, 1'b0);
		reg_check(ADDR_CTRL, 32'h00000100);
		for (int i = 0; i < 13; i++)
			run_case(t_cfg[i], t_info[i], t_short[i] ? 40 : 70, t_acc[i],
				1'b0);
		end_sim();
	end

	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		end_sim();
	end
endmodule : tb_top
